//--- hdl/fjm_jitter.sv
// Frequency jitter modulator with a complementary PWM output pair.
// Assumes control bytes and strobes come from logic on mclk; protection inputs too.
`timescale 1ns/10ps
module fjm_jitter
  import fjm_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // PWM run control and initial values
  input wire logic pwm_run_enable,
  input wire logic values_load,
  input fjm_vals_s values_init,
  // Software enable write port
  input wire logic soft_jitter_enable_wr,
  input wire logic soft_jitter_enable_wdata,
  // Mode selection
  input wire logic hardware_mode_select,
  input wire logic approach_select,
  input wire logic soft_approach_variant,
  // Count-mode controls
  input wire logic [7:0] count_step_control,
  input wire logic [7:0] count_dead_first_control,
  input wire logic [7:0] count_dead_second_control,
  // Approach-mode controls
  input wire logic [7:0] approach_step_control,
  input wire logic [7:0] approach_adapt_control,
  input wire logic [7:0] approach_dead_first_control,
  input wire logic [7:0] approach_dead_second_control,
  // Approach targets
  input wire logic [FJM_PW-1:0] target_period_a,
  input wire logic [FJM_PW-1:0] target_period_b,
  input wire logic [FJM_DW-1:0] dead_target_a_first,
  input wire logic [FJM_DW-1:0] dead_target_a_second,
  input wire logic [FJM_DW-1:0] dead_target_b_first,
  input wire logic [FJM_DW-1:0] dead_target_b_second,
  // Protection status
  input wire logic protection_trigger,
  input wire logic protect_adjust_flag,
  // Status and values
  output logic soft_jitter_enable,
  output fjm_vals_s jitter_values,
  output fjm_vals_s active_values,
  // Power stage drive
  output logic pwm_high,
  output logic pwm_low
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Step a period toward a target, landing on it when close
  function automatic logic [FJM_PW-1:0] fjm_toward(input logic [FJM_PW-1:0] cur,
                                                   input logic [FJM_PW-1:0] tgt,
                                                   input logic [FJM_PW-1:0] step);
    logic [FJM_PW-1:0] r;
    r = cur;
    if (tgt > cur) begin
      r = ((tgt - cur) <= step) ? tgt : cur + step;
    end else if (tgt < cur) begin
      r = ((cur - tgt) <= step) ? tgt : cur - step;
    end
    return r;
  endfunction : fjm_toward

  // Duty follows half of the period change; never wraps below zero
  function automatic logic [FJM_PW-1:0] fjm_duty(input logic [FJM_PW-1:0] duty,
                                                 input logic [FJM_PW-1:0] p_old,
                                                 input logic [FJM_PW-1:0] p_new);
    logic [FJM_PW-1:0] half;
    logic [FJM_PW-1:0] r;
    r = duty;
    half = (p_new >= p_old) ? (p_new - p_old) >> 1 : (p_old - p_new) >> 1;
    if (p_new > p_old) begin
      r = duty + half;
    end else if (duty > half) begin
      r = duty - half;
    end
    return r;
  endfunction : fjm_duty

  // Saturating add or subtract on a dead-time
  function automatic logic [FJM_DW-1:0] fjm_dead_step(input logic [FJM_DW-1:0] v,
                                                      input logic [FJM_DW-1:0] amt,
                                                      input logic sub);
    logic [FJM_DW:0] s;
    s = sub ? ({1'b0, v} - {1'b0, amt}) : ({1'b0, v} + {1'b0, amt});
    if (s[FJM_DW]) begin
      return sub ? {FJM_DW{1'b0}} : {FJM_DW{1'b1}};
    end
    return s[FJM_DW-1:0];
  endfunction : fjm_dead_step

  // Three-bit field adaptation, saturating
  function automatic logic [2:0] fjm_adapt(input logic [2:0] v, input logic [1:0] code);
    logic [2:0] r;
    r = v;
    if (code == ADAPT_INC && v != 3'h7) begin
      r = v + 3'h1;
    end else if (code == ADAPT_DEC && v != 3'h0) begin
      r = v - 3'h1;
    end
    return r;
  endfunction : fjm_adapt

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  fjm_state_s s_reg; // Registered state
  fjm_state_s s_next; // Next state
  logic trig; // One PWM trigger
  logic ovf; // Period counter at its last count
  logic protect; // Any protection activity
  logic [FJM_PW-1:0] p_step; // Period change this trigger
  logic [FJM_PW-1:0] p_tgt; // Selected period target
  logic [FJM_DW-1:0] d1_tgt; // Selected first dead-time target
  logic [FJM_DW-1:0] d2_tgt; // Selected second dead-time target
  logic [4:0] d1_lim; // First dead-time divider, minus one
  logic [4:0] d2_lim; // Second dead-time divider, minus one

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    protect = protection_trigger | protect_adjust_flag;
    p_step = '0;
    p_tgt = soft_approach_variant ? target_period_b : target_period_a;
    d1_tgt = soft_approach_variant ? dead_target_b_first : dead_target_a_first;
    d2_tgt = soft_approach_variant ? dead_target_b_second : dead_target_a_second;
    d1_lim = '0;
    d2_lim = '0;
    // Counter wraps at the active period; zero period still wraps each cycle
    ovf = pwm_run_enable && (s_reg.pwm_cnt + 16'h0001 >= s_reg.act.period);
    // Trigger only on overflow or the run rising edge, so nothing moves while off
    trig = pwm_run_enable && (ovf || !s_reg.run_d);
    s_next.run_d = pwm_run_enable;
    // Period counter
    if (!pwm_run_enable || ovf) begin
      s_next.pwm_cnt = '0;
    end else begin
      s_next.pwm_cnt = s_reg.pwm_cnt + 16'h0001;
    end
    // Complementary outputs with dead bands at both edges of the high pulse
    s_next.hi = pwm_run_enable && s_reg.pwm_cnt >= FJM_PW'(s_reg.act.dead_first) &&
                s_reg.pwm_cnt < s_reg.act.duty;
    s_next.lo = pwm_run_enable && s_reg.pwm_cnt >= s_reg.act.duty + FJM_PW'(s_reg.act.dead_second) &&
                s_reg.pwm_cnt < s_reg.act.period;

    // Software enable; protection clears win over the software write
    if (soft_jitter_enable_wr) begin
      if (soft_jitter_enable_wdata && !s_reg.enable && protect) begin
        s_next.enable = 1'b0;
      end else begin
        s_next.enable = soft_jitter_enable_wdata;
      end
      // Accepted start: take fresh working copies of the adaptive fields
      if (soft_jitter_enable_wdata && !s_reg.enable && !protect) begin
        s_next.dir = 1'b0;
        s_next.step_cnt = RST_CNT3;
        s_next.adapt_cnt = RST_CNT3;
        s_next.dead_cnt_first = RST_CNT5;
        s_next.dead_cnt_second = RST_CNT5;
        s_next.cur_cnt = approach_step_control[AS_CNT_LSB+:3];
        s_next.cur_amt = approach_step_control[AS_AMT_LSB+:3];
        s_next.dead_amt_first = approach_dead_first_control[AD_AMT_LSB+:3];
        s_next.dead_amt_second = approach_dead_second_control[AD_AMT_LSB+:3];
      end
    end
    if (s_reg.enable && protect) begin
      s_next.enable = 1'b0;
    end

    // Only the software modes run here
    if (!s_next.enable || hardware_mode_select) begin
      s_next.mode = FJM_IDLE;
    end else begin
      s_next.mode = approach_select ? FJM_APPROACH : FJM_COUNT;
    end

    // Software may preload the working values while jitter is stopped
    if (values_load && !s_reg.enable) begin
      s_next.vals = values_init;
    end

    if (trig) begin
      // Values computed at the previous trigger go live now
      s_next.act = s_reg.vals;
      unique case (s_reg.mode)
        FJM_IDLE: begin
          // Values stay as software left them
        end
        FJM_COUNT: begin
          // Period changes by twice amount+1, duty by half of that
          p_step = FJM_PW'({count_step_control[CS_AMT_LSB+:3], 1'b0}) + 16'h0002;
          if (s_reg.dir ^ count_step_control[CS_DIR_BIT]) begin
            s_next.vals.period = s_reg.vals.period - p_step;
          end else begin
            s_next.vals.period = s_reg.vals.period + p_step;
          end
          s_next.vals.duty = fjm_duty(s_reg.vals.duty, s_reg.vals.period, s_next.vals.period);
          // Reverse once the programmed step count is spent
          if (s_reg.step_cnt == count_step_control[CS_TIMES_LSB+:3]) begin
            s_next.step_cnt = RST_CNT3;
            s_next.dir = !s_reg.dir;
          end else begin
            s_next.step_cnt = s_reg.step_cnt + 3'h1;
          end
          // Dead-times: own enable, divider and direction each
          d1_lim = {3'h0, count_dead_first_control[CD_DIV_LSB+:2]};
          d2_lim = {3'h0, count_dead_second_control[CD_DIV_LSB+:2]};
          if (count_dead_first_control[CD_EN_BIT]) begin
            s_next.dead_cnt_first = (s_reg.dead_cnt_first == d1_lim) ? RST_CNT5 :
                                    s_reg.dead_cnt_first + 5'h01;
            if (s_reg.dead_cnt_first == d1_lim) begin
              s_next.vals.dead_first = fjm_dead_step(s_reg.vals.dead_first,
                FJM_DW'(count_dead_first_control[CD_AMT_LSB+:2]) + 8'h01,
                count_dead_first_control[CD_DIR_BIT]);
            end
          end
          if (count_dead_second_control[CD_EN_BIT]) begin
            s_next.dead_cnt_second = (s_reg.dead_cnt_second == d2_lim) ? RST_CNT5 :
                                     s_reg.dead_cnt_second + 5'h01;
            if (s_reg.dead_cnt_second == d2_lim) begin
              s_next.vals.dead_second = fjm_dead_step(s_reg.vals.dead_second,
                FJM_DW'(count_dead_second_control[CD_AMT_LSB+:2]) + 8'h01,
                count_dead_second_control[CD_DIR_BIT]);
            end
          end
        end
        FJM_APPROACH: begin
          // Period and duty step every cur_cnt+1 triggers
          if (s_reg.step_cnt == s_reg.cur_cnt) begin
            s_next.step_cnt = RST_CNT3;
            p_step = AS_PERIOD_STEP[s_reg.cur_amt];
            // Hold once the target is reached
            s_next.vals.period = fjm_toward(s_reg.vals.period, p_tgt, p_step);
            s_next.vals.duty = fjm_duty(s_reg.vals.duty, s_reg.vals.period,
                                        s_next.vals.period);
            // Adapt step spacing and amounts after the programmed adjustments
            if (s_reg.adapt_cnt == approach_adapt_control[AA_NUM_LSB+:3]) begin
              s_next.adapt_cnt = RST_CNT3;
              s_next.cur_cnt = fjm_adapt(s_reg.cur_cnt,
                                         approach_adapt_control[AA_CNT_LSB+:2]);
              s_next.cur_amt = fjm_adapt(s_reg.cur_amt,
                                         approach_adapt_control[AA_AMT_LSB+:2]);
              s_next.dead_amt_first = fjm_adapt(s_reg.dead_amt_first,
                approach_dead_first_control[AD_ADAPT_LSB+:2]);
              s_next.dead_amt_second = fjm_adapt(s_reg.dead_amt_second,
                approach_dead_second_control[AD_ADAPT_LSB+:2]);
            end else begin
              s_next.adapt_cnt = s_reg.adapt_cnt + 3'h1;
            end
          end else begin
            s_next.step_cnt = s_reg.step_cnt + 3'h1;
          end
          // Dead-times step every 4 << divider triggers toward their own targets
          d1_lim = 5'(5'h04 << approach_dead_first_control[AD_DIV_LSB+:2]) - 5'h01;
          d2_lim = 5'(5'h04 << approach_dead_second_control[AD_DIV_LSB+:2]) - 5'h01;
          if (approach_dead_first_control[AD_EN_BIT]) begin
            s_next.dead_cnt_first = (s_reg.dead_cnt_first == d1_lim) ? RST_CNT5 :
                                    s_reg.dead_cnt_first + 5'h01;
            if (s_reg.dead_cnt_first == d1_lim) begin
              s_next.vals.dead_first = FJM_DW'(fjm_toward(FJM_PW'(s_reg.vals.dead_first),
                FJM_PW'(d1_tgt), FJM_PW'(s_reg.dead_amt_first) + 16'h0001));
            end
          end
          if (approach_dead_second_control[AD_EN_BIT]) begin
            s_next.dead_cnt_second = (s_reg.dead_cnt_second == d2_lim) ? RST_CNT5 :
                                     s_reg.dead_cnt_second + 5'h01;
            if (s_reg.dead_cnt_second == d2_lim) begin
              s_next.vals.dead_second = FJM_DW'(fjm_toward(FJM_PW'(s_reg.vals.dead_second),
                FJM_PW'(d2_tgt), FJM_PW'(s_reg.dead_amt_second) + 16'h0001));
            end
          end
        end
        default: begin
          // Illegal code falls back to idle
          s_next.mode = FJM_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state flops
  assign soft_jitter_enable = s_reg.enable;
  assign jitter_values = s_reg.vals;
  assign active_values = s_reg.act;
  assign pwm_high = s_reg.hi;
  assign pwm_low = s_reg.lo;

endmodule : fjm_jitter

//--- shared/fjm_pkg.sv
// Constants, field layouts and carrier types for the frequency jitter modulator.
// Assumes one 125 MHz clock domain; all control bytes arrive from logic on that clock.
package fjm_pkg;

  // ----------------------------------------------------------------
  // Widths and clock
  // ----------------------------------------------------------------
  localparam int FJM_PW = 16; // Period and duty width
  localparam int FJM_DW = 8; // Dead-time width
  localparam int FJM_CLK_MHZ = 125; // Clock rate, mclk

  // ----------------------------------------------------------------
  // Count-mode step control byte
  // ----------------------------------------------------------------
  localparam int CS_TIMES_LSB = 4; // Step times, 3 bits, value+1 steps
  localparam int CS_DIR_BIT = 3; // 0 add, 1 subtract
  localparam int CS_AMT_LSB = 0; // Step amount, 3 bits

  // ----------------------------------------------------------------
  // Count-mode dead-time control bytes
  // ----------------------------------------------------------------
  localparam int CD_EN_BIT = 7; // Adjustment enable
  localparam int CD_DIV_LSB = 4; // Divider, 2 bits, value+1 triggers
  localparam int CD_DIR_BIT = 3; // 0 add, 1 subtract
  localparam int CD_AMT_LSB = 0; // Amount, 2 bits, value+1

  // ----------------------------------------------------------------
  // Approach-mode control bytes
  // ----------------------------------------------------------------
  localparam int AS_CNT_LSB = 4; // Trigger count, 3 bits, value+1
  localparam int AS_AMT_LSB = 0; // Step amount code, 3 bits
  localparam int AA_NUM_LSB = 4; // Adjustments between adaptations, 3 bits
  localparam int AA_CNT_LSB = 2; // Trigger count adaptation code
  localparam int AA_AMT_LSB = 0; // Step amount adaptation code
  localparam int AD_EN_BIT = 7; // Dead-time adjustment enable
  localparam int AD_ADAPT_LSB = 5; // Dead amount adaptation code
  localparam int AD_DIV_LSB = 3; // Divider, 2 bits, 4 << value triggers
  localparam int AD_AMT_LSB = 0; // Dead amount, 3 bits, value+1

  // Adaptation codes
  localparam logic [1:0] ADAPT_KEEP = 2'h0;
  localparam logic [1:0] ADAPT_INC = 2'h1;
  localparam logic [1:0] ADAPT_DEC = 2'h2;

  // Approach step amount code to period change
  localparam logic [7:0][FJM_PW-1:0] AS_PERIOD_STEP = {
    16'h000C, 16'h000A, 16'h0008, 16'h0006, 16'h0005, 16'h0004, 16'h0003, 16'h0002};

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [FJM_PW-1:0] RST_PERIOD = 16'h0000;
  localparam logic [FJM_DW-1:0] RST_DEAD = 8'h00;
  localparam logic [2:0] RST_CNT3 = 3'h0;
  localparam logic [4:0] RST_CNT5 = 5'h00;

  // Jitter mode, Gray along idle -> count / approach
  typedef enum logic [1:0] {
    FJM_IDLE = 2'b00,
    FJM_COUNT = 2'b01,
    FJM_APPROACH = 2'b10
  } fjm_mode_e;

  // One set of period, duty and dead-time values
  typedef struct packed {
    logic [FJM_PW-1:0] period;
    logic [FJM_PW-1:0] duty;
    logic [FJM_DW-1:0] dead_first;
    logic [FJM_DW-1:0] dead_second;
  } fjm_vals_s;

  // Whole module state
  typedef struct packed {
    fjm_mode_e mode;
    logic enable;
    fjm_vals_s vals;
    fjm_vals_s act;
    logic [FJM_PW-1:0] pwm_cnt;
    logic run_d;
    logic dir;
    logic [2:0] step_cnt;
    logic [2:0] adapt_cnt;
    logic [2:0] cur_cnt;
    logic [2:0] cur_amt;
    logic [2:0] dead_amt_first;
    logic [2:0] dead_amt_second;
    logic [4:0] dead_cnt_first;
    logic [4:0] dead_cnt_second;
    logic hi;
    logic lo;
  } fjm_state_s;

endpackage : fjm_pkg

//--- tb/fjm_checker.sv
// Concurrent checks on the jitter modulator's ports.
// Assumes one mclk domain, bound into fjm_jitter from the testbench.
`timescale 1ns/10ps
module fjm_checker
  import fjm_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Inputs watched
  input wire logic pwm_run_enable,
  input wire logic soft_jitter_enable_wr,
  input wire logic soft_jitter_enable_wdata,
  input wire logic hardware_mode_select,
  input wire logic approach_select,
  input wire logic soft_approach_variant,
  input wire logic [FJM_PW-1:0] target_period_a,
  input wire logic protection_trigger,
  input wire logic protect_adjust_flag,
  // Outputs watched
  input wire logic soft_jitter_enable,
  input fjm_vals_s jitter_values,
  input fjm_vals_s active_values
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic prot; // Either protection source active
  assign prot = protection_trigger || protect_adjust_flag;
  sequence s_trig; // Run rising edge
    !pwm_run_enable ##1 pwm_run_enable;
  endsequence
  sequence s_start; // Software start request
    !soft_jitter_enable && soft_jitter_enable_wr && soft_jitter_enable_wdata;
  endsequence
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_prot_clears_en:
    assert property (soft_jitter_enable && prot |=> !soft_jitter_enable) else $error("enable kept");
  a_start_refused:
    assert property (s_start ##0 prot |=> !soft_jitter_enable) else $error("start not refused");
  a_start_taken:
    assert property (s_start ##0 !prot |=> soft_jitter_enable) else $error("start lost");
  a_idle_holds:
    assert property (!pwm_run_enable && soft_jitter_enable |=>
      $stable(jitter_values) && $stable(active_values)) else $error("values moved while off");
  a_active_lags:
    assert property (s_trig |=> active_values == $past(jitter_values)) else $error("active late");
  a_hw_no_adjust:
    assert property (hardware_mode_select && soft_jitter_enable |=> $stable(jitter_values))
      else $error("hardware mode adjusted");
  a_duty_half:
    assert property (soft_jitter_enable && $past(soft_jitter_enable) && !approach_select
      && !hardware_mode_select && $changed(jitter_values.period) |->
      16'(jitter_values.period - $past(jitter_values.period)) ==
      16'((jitter_values.duty - $past(jitter_values.duty)) << 1)) else $error("duty not half");
  a_target_hold:
    assert property (soft_jitter_enable && approach_select && !soft_approach_variant
      && !hardware_mode_select && jitter_values.period == target_period_a |=>
      jitter_values.period == target_period_a) else $error("left target");
endmodule : fjm_checker

//--- tb/fjm_power_stage.sv
// Half-bridge model: counts cycles with both switches driven.
// Assumes active-high drive registered on mclk.
`timescale 1ns/10ps
module fjm_power_stage (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Gate drive
  input wire logic pwm_high,
  input wire logic pwm_low,
  // Shoot-through tally
  output logic [15:0] overlap_count
);
  // Both switches on shorts the rail, so every such cycle is tallied
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      overlap_count <= 16'h0000;
    end else if (pwm_high && pwm_low) begin
      overlap_count <= overlap_count + 16'h0001;
    end
  end
endmodule : fjm_power_stage

//--- tb/fjm_testbench.sv
// Self-checking bench for the jitter modulator.
// Assumes the checker and power stage model are compiled first.
`timescale 1ns/10ps
module testbench;
  import fjm_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic mclk = 1'b0;
  logic rst_n, run, load, wr, wdata, hw, apr, var_b, prot, adj, en, ph, pl;
  logic [7:0] csc, cd1, cd2, asc, aac, ad1, ad2;
  logic [15:0] tpa, tpb, p, overlap_count;
  fjm_vals_s vinit, jv, av, prev, e;
  fjm_vals_s init_v = {16'h01F4, 16'h00FA, 8'h40, 8'h20};
  int miscompares = 0;
  int checks = 0;
  int cycles = 0;
  int high_cycles = 0; // Cycles with the high-side drive on
  int low_cycles = 0; // Cycles with the low-side drive on
  bit up;
  always #4 mclk = ~mclk;
  fjm_jitter DUT (.mclk(mclk), .rst_n(rst_n), .pwm_run_enable(run), .values_load(load),
    .values_init(vinit), .soft_jitter_enable_wr(wr), .soft_jitter_enable_wdata(wdata),
    .hardware_mode_select(hw), .approach_select(apr), .soft_approach_variant(var_b),
    .count_step_control(csc), .count_dead_first_control(cd1), .count_dead_second_control(cd2),
    .approach_step_control(asc), .approach_adapt_control(aac),
    .approach_dead_first_control(ad1), .approach_dead_second_control(ad2),
    .target_period_a(tpa), .target_period_b(tpb), .dead_target_a_first(8'h44),
    .dead_target_a_second(8'h1E), .dead_target_b_first(8'h3E), .dead_target_b_second(8'h20),
    .protection_trigger(prot), .protect_adjust_flag(adj), .soft_jitter_enable(en),
    .jitter_values(jv), .active_values(av), .pwm_high(ph), .pwm_low(pl));
  fjm_power_stage PS (.mclk(mclk), .rst_n(rst_n), .pwm_high(ph), .pwm_low(pl),
    .overlap_count(overlap_count));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task chk(input string nm, input logic [47:0] got, input logic [47:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  task wr_en(input logic v); // Software writes the enable bit
    @(posedge mclk);
    wr <= 1'b1;
    wdata <= v;
    @(posedge mclk);
    wr <= 1'b0;
    tick(3);
  endtask : wr_en
  task load_vals; // Initial values, only while disabled
    @(posedge mclk);
    vinit <= init_v;
    load <= 1'b1;
    @(posedge mclk);
    load <= 1'b0;
    tick(2);
  endtask : load_vals
  task step(input fjm_vals_s x); // One run rising edge, then compare
    prev = jv;
    @(posedge mclk);
    run <= 1'b1;
    @(posedge mclk);
    run <= 1'b0;
    tick(2);
    chk("jitter_values", jv, x);
    chk("active_values", av, prev);
  endtask : step
  task final_report;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  // Hang guard, far above the roughly 1400 cycles needed
  always @(posedge mclk) begin
    cycles++;
    if (ph) high_cycles++;
    if (pl) low_cycles++;
    if (cycles == 20000) begin
      miscompares++;
      final_report();
    end
  end
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_n, run, load, wr, wdata, hw, apr, var_b, prot, adj} = '0;
    {csc, cd1, cd2, asc, aac, ad1, ad2} = {8'h33, 8'h13, 8'hB9, 8'h10, 8'h10, 8'h80, 8'h0C};
    {tpa, tpb, vinit} = {16'h01FE, 16'h01F0, init_v};
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    // Count mode, 33H / 13H / B9H
    load_vals();
    wr_en(1'b1);
    chk("enable", en, 1'b1);
    p = 16'h01F4;
    up = 1'b1;
    for (int k = 1; k <= 9; k++) begin
      p = up ? p + 16'h0008 : p - 16'h0008;
      if (k % 4 == 0) up = !up;
      e = {p, p >> 1, 8'h40, 8'h20 - 8'(k / 4 * 2)};
      step(e);
    end
    tick(20);
    chk("idle values", jv, e);
    // Protection clears, then refuses a start
    @(posedge mclk);
    prot <= 1'b1;
    @(posedge mclk);
    prot <= 1'b0;
    tick(1);
    chk("cleared enable", en, 1'b0);
    @(posedge mclk) adj <= 1'b1;
    wr_en(1'b1);
    chk("refused enable", en, 1'b0);
    @(posedge mclk) adj <= 1'b0;
    // Approach variant A toward 510, first dead-time toward 68
    load_vals();
    @(posedge mclk) apr <= 1'b1;
    wr_en(1'b1);
    for (int k = 1; k <= 16; k++) begin
      p = 16'h01F4 + 16'(k / 2 * 2);
      if (p > 16'h01FE) p = 16'h01FE;
      e = {p, p >> 1, 8'h40 + 8'(k / 4), 8'h20};
      step(e);
    end
    // Approach variant B downward toward 496
    wr_en(1'b0);
    load_vals();
    @(posedge mclk) var_b <= 1'b1;
    aac <= 8'h04; // Step spacing grows by one after every step
    wr_en(1'b1);
    for (int k = 1; k <= 6; k++) begin
      p = (k < 2) ? 16'h01F4 : (k < 5) ? 16'h01F2 : 16'h01F0;
      e = {p, p >> 1, 8'h40 - 8'(k / 4), 8'h20};
      step(e);
    end
    // Hardware mode: no software adjustment
    wr_en(1'b0);
    @(posedge mclk) hw <= 1'b1;
    wr_en(1'b1);
    e = jv;
    for (int k = 0; k < 3; k++) step(e);
    // Free run through whole periods
    @(posedge mclk);
    run <= 1'b1;
    tick(1200);
    @(posedge mclk) run <= 1'b0;
    tick(2);
    chk("overlap cycles", overlap_count, 16'h0000);
    chk("high cycles", high_cycles >= 300, 1'b1);
    chk("low cycles", low_cycles >= 300, 1'b1);
    final_report();
  end
endmodule : testbench
bind fjm_jitter fjm_checker u_chk (.mclk(mclk), .rst_n(rst_n), .pwm_run_enable(pwm_run_enable),
  .soft_jitter_enable_wr(soft_jitter_enable_wr),
  .soft_jitter_enable_wdata(soft_jitter_enable_wdata),
  .hardware_mode_select(hardware_mode_select), .approach_select(approach_select),
  .soft_approach_variant(soft_approach_variant), .target_period_a(target_period_a),
  .protection_trigger(protection_trigger), .protect_adjust_flag(protect_adjust_flag),
  .soft_jitter_enable(soft_jitter_enable), .jitter_values(jitter_values),
  .active_values(active_values));
